//--- shared/annp_map.svh
// Register offsets, field positions, reset values and frame constants of the next-page and status bank.
`ifndef ANNP_MAP_SVH
`define ANNP_MAP_SVH

// ----------------------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------------------
`define ANNP_REG_NEXT_PAGE_TRANSMIT  5'h07
`define ANNP_REG_PHY_SUMMARY_STATUS  5'h10
`define ANNP_REG_FALSE_CARRIER_CNT   5'h14
`define ANNP_REG_RECEIVE_ERROR_CNT   5'h15
`define ANNP_REG_TENBASE_STATUS_CTL  5'h1A

// ----------------------------------------------------------------------------
// Next-page transmit fields
// ----------------------------------------------------------------------------
`define ANNP_NPT_NEXT_PAGE_BIT       15
`define ANNP_NPT_RESERVED_BIT        14
`define ANNP_NPT_MESSAGE_PAGE_BIT    13
`define ANNP_NPT_COMPLY_ACK_BIT      12
`define ANNP_NPT_TOGGLE_BIT          11
`define ANNP_NPT_CODE_MSB            10
`define ANNP_NPT_CODE_W              11
`define ANNP_NPT_NEXT_PAGE_RST       1'h0
`define ANNP_NPT_MESSAGE_PAGE_RST    1'h1
`define ANNP_NPT_COMPLY_ACK_RST      1'h0
`define ANNP_NPT_TOGGLE_RST          1'h0
`define ANNP_NPT_CODE_RST            11'h001

// ----------------------------------------------------------------------------
// Summary status fields
// ----------------------------------------------------------------------------
`define ANNP_STS_RESERVED_BIT        15
`define ANNP_STS_CROSSOVER_BIT       14
`define ANNP_STS_RX_ERROR_BIT        13
`define ANNP_STS_POLARITY_BIT        12
`define ANNP_STS_FALSE_CARRIER_BIT   11

// ----------------------------------------------------------------------------
// Management frame
// ----------------------------------------------------------------------------
`define ANNP_PHY_ADDR                5'h01
`define ANNP_PREAMBLE_LEN            6'h20
`define ANNP_HDR_BITS                5'h0E
`define ANNP_START                   2'h1
`define ANNP_OP_WRITE                2'h1
`define ANNP_OP_READ                 2'h2
`define ANNP_DATA_LAST               5'h0F

`endif

//--- shared/annp_pkg.sv
// Types shared by the next-page and status bank.
package annp_pkg;

  typedef enum logic [4:0] {
    ANNP_ST_PREAMBLE = 5'b00001,
    ANNP_ST_HEADER   = 5'b00010,
    ANNP_ST_TURN     = 5'b00100,
    ANNP_ST_READ     = 5'b01000,
    ANNP_ST_WRITE    = 5'b10000
  } annp_state_e;

  typedef logic [15:0] annp_word_t;

endpackage

//--- hdl/annp_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ns

module annp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

//--- hdl/annp_regs.sv
// Next-page transmit and summary status registers behind the serial management port.
`timescale 1ns/1ns
`include "annp_map.svh"

module annp_regs (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // Serial management pins
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  // Arbitration side
  input  wire logic        lcw_exchanged_i,
  input  wire logic        lcw_toggle_i,
  output logic             next_page_flag_o,
  output logic             message_page_flag_o,
  output logic             comply_acknowledge_o,
  output logic             page_toggle_bit_o,
  output logic [10:0]      page_code_o,
  // Crossover and line events
  input  wire logic        auto_crossover_enable_i,
  input  wire logic        crossover_force_i,
  input  wire logic        crossover_swapped_i,
  input  wire logic        rx_error_event_i,
  input  wire logic        false_carrier_event_i,
  input  wire logic        polarity_inverted_i
);

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic       mdc_d_reg;
  logic       mdc_rise;
  logic       mdio_s;

  annp_sync #(.WIDTH(2)) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({mdc_i, mdio_i}),
    .sync_o    (pins_sync)
  );

  assign mdio_s   = pins_sync[0];
  assign mdc_rise = pins_sync[1] & ~mdc_d_reg;

  // --------------------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------------------
  annp_pkg::annp_state_e state_reg,  state_next;
  logic [5:0]            cnt_reg,    cnt_next;
  annp_pkg::annp_word_t  sh_reg,     sh_next;
  logic [1:0]            op_reg,     op_next;
  logic [4:0]            addr_reg,   addr_next;
  logic                  match_reg,  match_next;
  logic                  mdio_reg,   mdio_next;
  logic                  oe_reg,     oe_next;
  logic [13:0]           hdr;
  annp_pkg::annp_word_t  wdata;
  annp_pkg::annp_word_t  rdata;
  logic                  owned;
  logic                  rd_take;
  logic                  wr_take;

  assign hdr   = {sh_reg[12:0], mdio_s};
  assign wdata = {sh_reg[14:0], mdio_s};
  assign owned = (addr_reg == `ANNP_REG_NEXT_PAGE_TRANSMIT) || (addr_reg == `ANNP_REG_PHY_SUMMARY_STATUS);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    match_next = match_reg;
    mdio_next  = mdio_reg;
    oe_next    = oe_reg;
    rd_take    = 1'b0;
    wr_take    = 1'b0;
    if (mdc_rise) begin
      case (state_reg)
        annp_pkg::ANNP_ST_PREAMBLE: begin
          if (mdio_s) begin
            cnt_next = (cnt_reg == `ANNP_PREAMBLE_LEN) ? cnt_reg : cnt_reg + 6'h01;
          end else if (cnt_reg == `ANNP_PREAMBLE_LEN) begin
            state_next = annp_pkg::ANNP_ST_HEADER;
            sh_next    = 16'h0000;
            cnt_next   = 6'h01;
          end else begin
            cnt_next = 6'h00;
          end
        end
        annp_pkg::ANNP_ST_HEADER: begin
          sh_next  = {sh_reg[14:0], mdio_s};
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == {1'b0, `ANNP_HDR_BITS} - 6'h01) begin
            cnt_next   = 6'h00;
            op_next    = hdr[11:10];
            addr_next  = hdr[4:0];
            match_next = (hdr[9:5] == `ANNP_PHY_ADDR);
            state_next = (hdr[13:12] == `ANNP_START) ? annp_pkg::ANNP_ST_TURN : annp_pkg::ANNP_ST_PREAMBLE;
          end
        end
        annp_pkg::ANNP_ST_TURN: begin
          if (cnt_reg == 6'h00) begin
            cnt_next  = 6'h01;
            oe_next   = match_reg && (op_reg == `ANNP_OP_READ) && owned;
            mdio_next = 1'b0;
          end else begin
            cnt_next = 6'h00;
            if (op_reg == `ANNP_OP_READ) begin
              rd_take    = match_reg;
              mdio_next  = rdata[15];
              sh_next    = {rdata[14:0], 1'b0};
              state_next = annp_pkg::ANNP_ST_READ;
            end else if (op_reg == `ANNP_OP_WRITE) begin
              state_next = annp_pkg::ANNP_ST_WRITE;
            end else begin
              state_next = annp_pkg::ANNP_ST_PREAMBLE;
            end
          end
        end
        annp_pkg::ANNP_ST_READ: begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == {1'b0, `ANNP_DATA_LAST}) begin
            oe_next    = 1'b0;
            cnt_next   = 6'h00;
            state_next = annp_pkg::ANNP_ST_PREAMBLE;
          end else begin
            mdio_next = sh_reg[15];
            sh_next   = {sh_reg[14:0], 1'b0};
          end
        end
        annp_pkg::ANNP_ST_WRITE: begin
          sh_next  = wdata;
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == {1'b0, `ANNP_DATA_LAST}) begin
            wr_take    = match_reg && (addr_reg == `ANNP_REG_NEXT_PAGE_TRANSMIT);
            cnt_next   = 6'h00;
            state_next = annp_pkg::ANNP_ST_PREAMBLE;
          end
        end
        default: begin
          state_next = annp_pkg::ANNP_ST_PREAMBLE;
          cnt_next   = 6'h00;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mdc_d_reg <= 1'b0;
      state_reg <= annp_pkg::ANNP_ST_PREAMBLE;
      cnt_reg   <= 6'h00;
      sh_reg    <= 16'h0000;
      op_reg    <= 2'h0;
      addr_reg  <= 5'h00;
      match_reg <= 1'b0;
      mdio_reg  <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      mdc_d_reg <= pins_sync[1];
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      match_reg <= match_next;
      mdio_reg  <= mdio_next;
      oe_reg    <= oe_next;
    end
  end

  // --------------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------------
  logic        np_reg,     np_next;
  logic        mp_reg,     mp_next;
  logic        comply_acknowledge_reg,   comply_acknowledge_next;
  logic        tog_reg,    tog_next;
  logic [10:0] code_reg,   code_next;
  logic        xover_reg,  xover_next;
  logic        rxerr_reg,  rxerr_next;
  logic        pol_reg,    pol_next;
  logic        fcar_reg,   fcar_next;
  logic        clr_rxerr;
  logic        clr_fcar;
  logic        clr_pol;

  // Clears are keyed on any read frame whose PHY address matches, even for registers answered by other blocks.
  assign clr_rxerr = rd_take && (addr_reg == `ANNP_REG_RECEIVE_ERROR_CNT);
  assign clr_fcar  = rd_take && (addr_reg == `ANNP_REG_FALSE_CARRIER_CNT);
  assign clr_pol   = rd_take && (addr_reg == `ANNP_REG_TENBASE_STATUS_CTL);

  always_comb begin
    rdata = 16'h0000;
    if (addr_reg == `ANNP_REG_NEXT_PAGE_TRANSMIT) begin
      rdata[`ANNP_NPT_NEXT_PAGE_BIT]    = np_reg;
      rdata[`ANNP_NPT_RESERVED_BIT]     = 1'b0;
      rdata[`ANNP_NPT_MESSAGE_PAGE_BIT] = mp_reg;
      rdata[`ANNP_NPT_COMPLY_ACK_BIT]   = comply_acknowledge_reg;
      rdata[`ANNP_NPT_TOGGLE_BIT]       = tog_reg;
      rdata[`ANNP_NPT_CODE_MSB:0]       = code_reg;
    end else if (addr_reg == `ANNP_REG_PHY_SUMMARY_STATUS) begin
      rdata[`ANNP_STS_RESERVED_BIT]      = 1'b0;
      rdata[`ANNP_STS_CROSSOVER_BIT]     = xover_reg;
      rdata[`ANNP_STS_RX_ERROR_BIT]      = rxerr_reg;
      rdata[`ANNP_STS_POLARITY_BIT]      = pol_reg;
      rdata[`ANNP_STS_FALSE_CARRIER_BIT] = fcar_reg;
    end
  end

  always_comb begin
    np_next   = np_reg;
    mp_next   = mp_reg;
    comply_acknowledge_next = comply_acknowledge_reg;
    code_next = code_reg;
    if (wr_take) begin
      np_next   = wdata[`ANNP_NPT_NEXT_PAGE_BIT];
      mp_next   = wdata[`ANNP_NPT_MESSAGE_PAGE_BIT];
      comply_acknowledge_next = wdata[`ANNP_NPT_COMPLY_ACK_BIT];
      code_next = wdata[`ANNP_NPT_CODE_MSB:0];
    end
    tog_next   = lcw_exchanged_i ? ~lcw_toggle_i : tog_reg;
    xover_next = crossover_force_i | (auto_crossover_enable_i & crossover_swapped_i);
    // A new event in the cycle of the clearing read is kept: set wins over clear.
    rxerr_next = rx_error_event_i      | (rxerr_reg & ~clr_rxerr);
    fcar_next  = false_carrier_event_i | (fcar_reg & ~clr_fcar);
    pol_next   = polarity_inverted_i   | (pol_reg & ~clr_pol);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      np_reg    <= `ANNP_NPT_NEXT_PAGE_RST;
      mp_reg    <= `ANNP_NPT_MESSAGE_PAGE_RST;
      comply_acknowledge_reg  <= `ANNP_NPT_COMPLY_ACK_RST;
      tog_reg   <= `ANNP_NPT_TOGGLE_RST;
      code_reg  <= `ANNP_NPT_CODE_RST;
      xover_reg <= 1'b0;
      rxerr_reg <= 1'b0;
      pol_reg   <= 1'b0;
      fcar_reg  <= 1'b0;
    end else begin
      np_reg    <= np_next;
      mp_reg    <= mp_next;
      comply_acknowledge_reg  <= comply_acknowledge_next;
      tog_reg   <= tog_next;
      code_reg  <= code_next;
      xover_reg <= xover_next;
      rxerr_reg <= rxerr_next;
      pol_reg   <= pol_next;
      fcar_reg  <= fcar_next;
    end
  end

  assign mdio_o               = mdio_reg;
  assign mdio_oe_o            = oe_reg;
  assign next_page_flag_o     = np_reg;
  assign message_page_flag_o  = mp_reg;
  assign comply_acknowledge_o = comply_acknowledge_reg;
  assign page_toggle_bit_o    = tog_reg;
  assign page_code_o          = code_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // The reset check must run while reset is low, so it opts out of the default disable.
  property p_reset_values;
    @(posedge ref_clk_i) disable iff (1'b0) !resetn_i |=> (!np_reg && mp_reg && !comply_acknowledge_reg && code_reg == 11'h001);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Next-page reset values wrong.");
  property p_write_fields;
    wr_take |=> (np_reg == $past(wdata[15]) && mp_reg == $past(wdata[13]) && comply_acknowledge_reg == $past(wdata[12])
                 && code_reg == $past(wdata[10:0]));
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("Next-page write not stored.");
  property p_hold_fields;
    !wr_take |=> $stable(np_reg) && $stable(mp_reg) && $stable(comply_acknowledge_reg) && $stable(code_reg);
  endproperty
  a_hold_fields: assert property (p_hold_fields) else $error("Next-page field changed without write.");
  property p_reserved_zero;
    (rdata[14] == 1'b0 || addr_reg != `ANNP_REG_NEXT_PAGE_TRANSMIT)
      && (rdata[15] == 1'b0 || addr_reg != `ANNP_REG_PHY_SUMMARY_STATUS);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit reads non-zero.");
  property p_toggle;
    lcw_exchanged_i |=> tog_reg == !$past(lcw_toggle_i) ##1 ($past(lcw_exchanged_i) || $stable(tog_reg));
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle bit not inverse of exchanged toggle.");
  property p_crossover;
    crossover_force_i |=> xover_reg;
  endproperty
  a_crossover: assert property (p_crossover) else $error("Forced crossover not reported.");
  property p_rxerr_hold;
    (rxerr_reg && !clr_rxerr) |=> rxerr_reg;
  endproperty
  a_rxerr_hold: assert property (p_rxerr_hold) else $error("Receive error latch lost.");
  property p_rxerr_clear;
    (clr_rxerr && !rx_error_event_i) |=> !rxerr_reg;
  endproperty
  a_rxerr_clear: assert property (p_rxerr_clear) else $error("Receive error latch not cleared.");
  property p_fcar;
    false_carrier_event_i |=> fcar_reg ##1 (fcar_reg || $past(clr_fcar));
  endproperty
  a_fcar: assert property (p_fcar) else $error("False carrier latch misbehaves.");
  property p_pol_keep;
    (pol_reg && rd_take && addr_reg == `ANNP_REG_PHY_SUMMARY_STATUS) |=> pol_reg;
  endproperty
  a_pol_keep: assert property (p_pol_keep) else $error("Polarity flag cleared by summary read.");
  property p_turn_drive;
    (state_reg == annp_pkg::ANNP_ST_TURN && rd_take && owned) |-> oe_reg && !mdio_reg;
  endproperty
  a_turn_drive: assert property (p_turn_drive) else $error("Turnaround zero not driven.");

  c_write: cover property (wr_take);
  c_read_status: cover property (rd_take && addr_reg == `ANNP_REG_PHY_SUMMARY_STATUS);
  c_clear_set_race: cover property (clr_rxerr && rx_error_event_i);
  c_toggle: cover property (lcw_exchanged_i ##1 lcw_exchanged_i);

endmodule

//--- testbench/annp_mgmt_model.sv
// Station manager model that runs read and write frames on the management pins.
`timescale 1ns/1ns

module annp_mgmt_model (
  // Clock
  input  wire logic ref_clk_i,
  // Management pins
  input  wire logic mdio_wire_i,
  output logic      mdc_o,
  output logic      mdio_oe_o,
  output logic      mdio_o
);
  // Half period in reference cycles; the bench raises it to act as a slow manager.
  int half = 8;

  initial begin
    mdc_o = 1'b0;
    mdio_oe_o = 1'b0;
    mdio_o = 1'b1;
  end

  // Data changes while the clock is low; the wire is sampled just before the rise.
  task automatic bit_time(input logic b, output logic s);
    mdio_o = b;
    repeat (half) @(negedge ref_clk_i);
    s = mdio_wire_i;
    mdc_o = 1'b1;
    repeat (half) @(negedge ref_clk_i);
    mdc_o = 1'b0;
  endtask

  // The clock stands still low outside a frame, so the device sees no stray edge.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] adr,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'h1, op, phy, adr};
    rd = 16'h0000;
    mdio_oe_o = 1'b1;
    for (int i = 0; i < 32; i++) begin
      bit_time(1'b1, s);
    end
    for (int i = 13; i >= 0; i--) begin
      bit_time(hdr[i], s);
    end
    if (op == 2'h2) begin
      mdio_oe_o = 1'b0;
      bit_time(1'b1, s);
      bit_time(1'b1, s);
    end else begin
      bit_time(1'b1, s);
      bit_time(1'b0, s);
    end
    for (int i = 15; i >= 0; i--) begin
      bit_time(wd[i], s);
      rd[i] = s;
    end
    mdio_oe_o = 1'b0;
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the next-page and status register bank.
`timescale 1ns/1ns
`include "annp_map.svh"

module tb;
  logic        ref_clk_i;
  logic        resetn_i;
  logic        mdc;
  logic        mgr_oe;
  logic        mgr_d;
  logic        mdio_d;
  logic        mdio_oe;
  logic        mdio_w;
  logic        lcw_exchanged;
  logic        lcw_toggle;
  logic        np_flag;
  logic        mp_flag;
  logic        ack_flag;
  logic        tog_flag;
  logic [10:0] code;
  logic [2:0]  xo;
  logic [2:0]  ev;
  logic [15:0] oe_cnt;
  int          error_cnt;
  int          n_compared;

  // The management line has a pull-up, so a released line reads high.
  assign mdio_w = mdio_oe ? mdio_d : (mgr_oe ? mgr_d : 1'b1);

  annp_mgmt_model sm_u (
    .ref_clk_i  (ref_clk_i),
    .mdio_wire_i(mdio_w),
    .mdc_o      (mdc),
    .mdio_oe_o  (mgr_oe),
    .mdio_o     (mgr_d)
  );

  annp_regs dut_u (
    .ref_clk_i              (ref_clk_i),
    .resetn_i               (resetn_i),
    .mdc_i                  (mdc),
    .mdio_i                 (mdio_w),
    .mdio_o                 (mdio_d),
    .mdio_oe_o              (mdio_oe),
    .lcw_exchanged_i        (lcw_exchanged),
    .lcw_toggle_i           (lcw_toggle),
    .next_page_flag_o       (np_flag),
    .message_page_flag_o    (mp_flag),
    .comply_acknowledge_o   (ack_flag),
    .page_toggle_bit_o      (tog_flag),
    .page_code_o            (code),
    .auto_crossover_enable_i(xo[2]),
    .crossover_force_i      (xo[1]),
    .crossover_swapped_i    (xo[0]),
    .rx_error_event_i       (ev[0]),
    .false_carrier_event_i  (ev[2]),
    .polarity_inverted_i    (ev[1])
  );

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (mdio_oe === 1'b1) begin
      oe_cnt <= oe_cnt + 16'h0001;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd(input logic [4:0] adr, output logic [15:0] d);
    sm_u.frame(`ANNP_OP_READ, `ANNP_PHY_ADDR, adr, 16'h0000, d);
  endtask

  task automatic wr(input logic [4:0] adr, input logic [15:0] wd);
    logic [15:0] d;
    sm_u.frame(`ANNP_OP_WRITE, `ANNP_PHY_ADDR, adr, wd, d);
  endtask

  task automatic rd_chk(input string name, input logic [4:0] adr, input logic [15:0] exp);
    logic [15:0] d;
    rd(adr, d);
    chk(name, exp, d);
  endtask

  function automatic logic [15:0] ports();
    return {np_flag, 1'b0, mp_flag, ack_flag, tog_flag, code};
  endfunction

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    chk("npt ports", 16'h2001, ports());
    oe_cnt = 16'h0000;
    rd_chk("npt reset", `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h2001);
    chk("read drive span", 16'h0110, oe_cnt);
    rd_chk("sts reset", `ANNP_REG_PHY_SUMMARY_STATUS, 16'h0000);
  endtask

  task automatic t_write();
    wr(`ANNP_REG_NEXT_PAGE_TRANSMIT, 16'hFFFF);
    rd_chk("npt all ones", `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'hB7FF);
    chk("npt ports ones", 16'hB7FF, ports());
    wr(`ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h2555);
    rd_chk("npt pattern", `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h2555);
    wr(`ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h4800);
    rd_chk("npt fixed bits", `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h0000);
  endtask

  task automatic t_toggle();
    for (int t = 0; t < 2; t++) begin
      @(negedge ref_clk_i);
      lcw_exchanged = 1'b1;
      lcw_toggle = t[0];
      @(negedge ref_clk_i);
      lcw_exchanged = 1'b0;
      lcw_toggle = ~t[0];
      @(negedge ref_clk_i);
      chk("toggle port", {15'h0000, ~t[0]}, {15'h0000, tog_flag});
      rd_chk("toggle read", `ANNP_REG_NEXT_PAGE_TRANSMIT, {4'h0, ~t[0], 11'h000});
    end
  endtask

  task automatic t_latch();
    logic [4:0] clr_adr;
    for (int i = 0; i < 3; i++) begin
      // The register whose read clears the flag that this pass sets.
      clr_adr = (i == 0) ? `ANNP_REG_RECEIVE_ERROR_CNT :
                (i == 1) ? `ANNP_REG_TENBASE_STATUS_CTL : `ANNP_REG_FALSE_CARRIER_CNT;
      @(negedge ref_clk_i);
      ev = 3'h1 << i;
      @(negedge ref_clk_i);
      ev = 3'h0;
      rd_chk("latch set", `ANNP_REG_PHY_SUMMARY_STATUS, 16'h2000 >> i);
      rd_chk("latch kept", `ANNP_REG_PHY_SUMMARY_STATUS, 16'h2000 >> i);
      wr(`ANNP_REG_PHY_SUMMARY_STATUS, 16'hFFFF);
      rd_chk("latch no write", `ANNP_REG_PHY_SUMMARY_STATUS, 16'h2000 >> i);
      wr(clr_adr, 16'h0000);
      rd_chk("latch write", `ANNP_REG_PHY_SUMMARY_STATUS, 16'h2000 >> i);
      rd_chk("foreign reg", clr_adr, 16'hFFFF);
      rd_chk("latch clear", `ANNP_REG_PHY_SUMMARY_STATUS, 16'h0000);
    end
  endtask

  task automatic t_cross();
    for (int c = 0; c < 8; c++) begin
      @(negedge ref_clk_i);
      xo = c[2:0];
      rd_chk("crossover", `ANNP_REG_PHY_SUMMARY_STATUS, {1'b0, c[1] | (c[2] & c[0]), 14'h0000});
    end
    xo = 3'h0;
  endtask

  task automatic t_refuse();
    logic [15:0] d;
    oe_cnt = 16'h0000;
    sm_u.frame(`ANNP_OP_READ, 5'h02, `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h0000, d);
    chk("foreign phy data", 16'hFFFF, d);
    chk("foreign phy drive", 16'h0000, oe_cnt);
    sm_u.frame(`ANNP_OP_WRITE, 5'h02, `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h2555, d);
    rd_chk("foreign phy write", `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h0000);
    rd_chk("unmapped", 5'h03, 16'hFFFF);
    sm_u.half = 12;
    wr(`ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h8000);
    rd_chk("slow manager", `ANNP_REG_NEXT_PAGE_TRANSMIT, 16'h8000);
    sm_u.half = 8;
  endtask

  // ----------------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Frames have fixed length, so only a stuck run can reach this limit.
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    error_cnt++;
    final_report();
  end

  initial begin
    resetn_i = 1'b0;
    lcw_exchanged = 1'b0;
    lcw_toggle = 1'b0;
    xo = 3'h0;
    ev = 3'h0;
    oe_cnt = 16'h0000;
    error_cnt = 0;
    n_compared = 0;
    repeat (20) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    t_reset();
    t_write();
    t_toggle();
    t_latch();
    t_cross();
    t_refuse();
    final_report();
  end
endmodule
